// ==== hw/atmtx_core.sv ====
// Transmit fill cell builder, errored cell insertion and cell counter
`timescale 1ns/1ps
`include "atmtx_regs.svh"
module atmtx_core (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Transmit FIFO side
    input wire logic fifo_cell_avail,
    input wire logic [7:0] fifo_data,
    output logic fifo_rd,
    // Outgoing cell stream
    input wire logic line_slot,
    output logic tx_valid,
    output logic tx_soc,
    output logic [7:0] tx_data,
    // Performance monitor and interrupt
    input wire logic perf_update_strobe,
    input wire logic port_summary_irq_en,
    output logic irq
);
    import atmtx_pkg::*;

    atmtx_state_t st_r;
    atmtx_state_t st_nxt;

    function automatic atmtx_rid_t rid_of(input logic [11:0] a);
        logic [9:0] i;
        i = a[11:2];
        if (a[1:0] != 2'h0) begin
            rid_of = RID_NONE;
        end else if (i == `ATMTX_IDX_CTRL) begin
            rid_of = RID_CTRL;
        end else if (i == `ATMTX_IDX_ECC) begin
            rid_of = RID_ECC;
        end else if (i == `ATMTX_IDX_MASK) begin
            rid_of = RID_MASK;
        end else if (i == `ATMTX_IDX_HDR_LO) begin
            rid_of = RID_HLO;
        end else if (i == `ATMTX_IDX_HDR_HI) begin
            rid_of = RID_HHI;
        end else if (i == `ATMTX_IDX_PAY) begin
            rid_of = RID_PAY;
        end else if (i == `ATMTX_IDX_STAT) begin
            rid_of = RID_STAT;
        end else if (i == `ATMTX_IDX_LAT) begin
            rid_of = RID_LAT;
        end else if (i == `ATMTX_IDX_IE) begin
            rid_of = RID_IE;
        end else if (i == `ATMTX_IDX_CNT_LO) begin
            rid_of = RID_CLO;
        end else if (i == `ATMTX_IDX_CNT_HI) begin
            rid_of = RID_CHI;
        end else begin
            rid_of = RID_NONE;
        end
    endfunction : rid_of

    // Byte-lane merge into a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = old;
        if (s[0]) begin
            merge16[7:0] = d[7:0];
        end
        if (s[1]) begin
            merge16[15:8] = d[15:8];
        end
    endfunction : merge16

    // CRC-8 with coset over the four header bytes
    function automatic logic [7:0] hec_of(input logic [31:0] h);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 31; i >= 0; i--) begin
            if (c[7] ^ h[i]) begin
                c = {c[6:0], 1'b0} ^ `ATMTX_HEC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        hec_of = c ^ `ATMTX_HEC_COSET;
    endfunction : hec_of

    // Cells per errored cell: x * 10^y, y limited to 6
    function automatic logic [23:0] period_of(input logic [6:0] r);
        logic [23:0] p;
        logic [27:0] prod;
        case (r[6:4])
            3'h0: p = 24'h00_0001;
            3'h1: p = 24'h00_000a;
            3'h2: p = 24'h00_0064;
            3'h3: p = 24'h00_03e8;
            3'h4: p = 24'h00_2710;
            3'h5: p = 24'h01_86a0;
            default: p = 24'h0f_4240;
        endcase
        prod = {24'h00_0000, r[3:0]} * {4'h0, p};
        period_of = prod[23:0];
    endfunction : period_of

    always_comb begin
        logic [31:0] hdr_v;
        logic [7:0] pay_v;
        logic [7:0] b;
        logic cell_inc;
        logic x_on;
        logic done_n;
        logic [15:0] m;
        atmtx_rid_t wr_id;
        atmtx_rid_t rd_id;
        hdr_v = 32'h0000_0000;
        pay_v = 8'h00;
        b = 8'h00;
        cell_inc = 1'b0;
        x_on = 1'b0;
        done_n = 1'b0;
        m = 16'h0000;
        wr_id = RID_NONE;
        rd_id = RID_NONE;
        st_nxt = st_r;
        st_nxt.fifo_rd = 1'b0;
        st_nxt.tx_valid = 1'b0;
        st_nxt.tx_soc = 1'b0;

        hdr_v = st_r.hdr_sel ? st_r.hdr : `ATMTX_IDLE_HDR;
        pay_v = st_r.pay_sel ? st_r.pay : `ATMTX_IDLE_PAY;
        x_on = (st_r.rate[3:0] != 4'h0);

        // Cell sequencer
        case (st_r.cst)
            CST_DECIDE: begin
                st_nxt.idx = 6'h00;
                st_nxt.from_fifo = fifo_cell_avail;
                st_nxt.fifo_rd = fifo_cell_avail;
                st_nxt.cst = fifo_cell_avail ? CST_FETCH : CST_READY;
                st_nxt.errored = 1'b0;
                if (x_on && (st_r.total == `ATMTX_TOTAL_CONT || st_r.sent < st_r.total)) begin
                    if (st_r.ecnt + 24'h00_0001 >= period_of(st_r.rate)) begin
                        st_nxt.errored = 1'b1;
                        st_nxt.ecnt = 24'h00_0000;
                    end else begin
                        st_nxt.ecnt = st_r.ecnt + 24'h00_0001;
                    end
                end
            end
            CST_FETCH: begin
                st_nxt.hold = fifo_data;
                st_nxt.cst = CST_READY;
            end
            default: begin
                if (line_slot) begin
                    if (st_r.from_fifo) begin
                        b = st_r.hold;
                    end else if (st_r.idx < `ATMTX_HEC_IDX) begin
                        b = hdr_v[{~st_r.idx[1:0], 3'h0} +: 8];
                    end else if (st_r.idx == `ATMTX_HEC_IDX) begin
                        b = hec_of(hdr_v);
                    end else begin
                        b = pay_v;
                    end
                    if (st_r.errored && st_r.idx == `ATMTX_HEC_IDX) begin
                        b = b ^ st_r.mask;
                    end
                    st_nxt.tx_valid = 1'b1;
                    st_nxt.tx_data = b;
                    st_nxt.tx_soc = (st_r.idx == 6'h00);
                    if (st_r.idx == `ATMTX_CELL_LAST) begin
                        st_nxt.cst = CST_DECIDE;
                        cell_inc = st_r.from_fifo;
                        if (st_r.errored && st_r.total != `ATMTX_TOTAL_CONT) begin
                            st_nxt.sent = st_r.sent + 8'h01;
                        end
                    end else begin
                        st_nxt.idx = st_r.idx + 6'h01;
                        if (st_r.from_fifo) begin
                            st_nxt.fifo_rd = 1'b1;
                            st_nxt.cst = CST_FETCH;
                        end
                    end
                end
            end
        endcase

        // Running and readable cell count
        if (perf_update_strobe) begin
            st_nxt.snap_cnt = st_r.run_cnt + {23'h00_0000, cell_inc};
            st_nxt.run_cnt = 24'h00_0000;
        end else begin
            st_nxt.run_cnt = st_r.run_cnt + {23'h00_0000, cell_inc};
        end

        // AXI write channel
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (s_axi_awvalid && st_r.awready) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_r.wready) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = s_axi_wdata;
            st_nxt.wstrb = s_axi_wstrb;
        end
        if (st_nxt.aw_got && st_nxt.w_got && !st_nxt.bvalid) begin
            wr_id = rid_of(st_nxt.awaddr);
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = (wr_id == RID_NONE) ? `ATMTX_RESP_SLVERR : `ATMTX_RESP_OKAY;
            case (wr_id)
                RID_CTRL: begin
                    m = merge16({10'h000, st_r.hdr_sel, st_r.pay_sel, 4'h0},
                                st_nxt.wdata, st_nxt.wstrb);
                    st_nxt.hdr_sel = m[`ATMTX_BIT_HDR_SEL];
                    st_nxt.pay_sel = m[`ATMTX_BIT_PAY_SEL];
                end
                RID_ECC: begin
                    m = merge16({1'b0, st_r.rate, st_r.total}, st_nxt.wdata, st_nxt.wstrb);
                    st_nxt.rate = m[`ATMTX_POS_RATE +: 7];
                    st_nxt.total = m[`ATMTX_POS_TOTAL +: 8];
                    st_nxt.ecnt = 24'h00_0000;
                    st_nxt.sent = 8'h00;
                    st_nxt.errored = 1'b0;
                end
                RID_MASK: begin
                    m = merge16({8'h00, st_r.mask}, st_nxt.wdata, st_nxt.wstrb);
                    st_nxt.mask = m[7:0];
                end
                RID_HLO: begin
                    st_nxt.hdr[15:0] = merge16(st_r.hdr[15:0], st_nxt.wdata, st_nxt.wstrb);
                end
                RID_HHI: begin
                    st_nxt.hdr[31:16] = merge16(st_r.hdr[31:16], st_nxt.wdata, st_nxt.wstrb);
                end
                RID_PAY: begin
                    m = merge16({8'h00, st_r.pay}, st_nxt.wdata, st_nxt.wstrb);
                    st_nxt.pay = m[7:0];
                end
                RID_LAT: begin
                    if (st_nxt.wstrb[0] && st_nxt.wdata[`ATMTX_BIT_DONE]) begin
                        st_nxt.latched = 1'b0;
                    end
                end
                RID_IE: begin
                    m = merge16({15'h0000, st_r.ie}, st_nxt.wdata, st_nxt.wstrb);
                    st_nxt.ie = m[`ATMTX_BIT_DONE];
                end
                default: begin
                end
            endcase
        end
        st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
        st_nxt.wready = !st_nxt.w_got && !st_nxt.bvalid;

        // AXI read channel
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_r.arready) begin
            rd_id = rid_of(s_axi_araddr);
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = (rd_id == RID_NONE) ? `ATMTX_RESP_SLVERR : `ATMTX_RESP_OKAY;
            case (rd_id)
                RID_CTRL: st_nxt.rdata = {26'h000_0000, st_r.hdr_sel, st_r.pay_sel, 4'h0};
                RID_ECC: st_nxt.rdata = {17'h0_0000, st_r.rate, st_r.total};
                RID_MASK: st_nxt.rdata = {24'h00_0000, st_r.mask};
                RID_HLO: st_nxt.rdata = {16'h0000, st_r.hdr[15:0]};
                RID_HHI: st_nxt.rdata = {16'h0000, st_r.hdr[31:16]};
                RID_PAY: st_nxt.rdata = {24'h00_0000, st_r.pay};
                RID_STAT: st_nxt.rdata = {31'h0000_0000, st_r.done};
                RID_LAT: st_nxt.rdata = {31'h0000_0000, st_r.latched};
                RID_IE: st_nxt.rdata = {31'h0000_0000, st_r.ie};
                RID_CLO: st_nxt.rdata = {16'h0000, st_r.snap_cnt[15:0]};
                RID_CHI: st_nxt.rdata = {24'h00_0000, st_r.snap_cnt[23:16]};
                default: st_nxt.rdata = 32'h0000_0000;
            endcase
        end
        st_nxt.arready = !st_nxt.rvalid;

        // Insertion finished status, latch and interrupt
        done_n = (st_nxt.rate[3:0] != 4'h0) && (st_nxt.total != `ATMTX_TOTAL_CONT)
                 && (st_nxt.sent == st_nxt.total);
        st_nxt.done = done_n;
        if (done_n && !st_r.done) begin
            st_nxt.latched = 1'b1;
        end
        st_nxt.irq = st_nxt.latched && st_nxt.ie && port_summary_irq_en;

        if (!aresetn) begin
            st_nxt = '0;
            st_nxt.cst = CST_DECIDE;
            st_nxt.hdr = `ATMTX_RST_HDR;
            st_nxt.pay = `ATMTX_RST_PAY;
            st_nxt.mask = `ATMTX_RST_MASK;
            st_nxt.rate = 7'(`ATMTX_RST_ECC >> `ATMTX_POS_RATE);
            st_nxt.run_cnt = `ATMTX_RST_CNT;
            st_nxt.snap_cnt = `ATMTX_RST_CNT;
        end
    end

    always_ff @(posedge aclk) begin
        st_r <= st_nxt;
    end

    assign s_axi_awready = st_r.awready;
    assign s_axi_wready = st_r.wready;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign fifo_rd = st_r.fifo_rd;
    assign tx_valid = st_r.tx_valid;
    assign tx_soc = st_r.tx_soc;
    assign tx_data = st_r.tx_data;
    assign irq = st_r.irq;
endmodule : atmtx_core

// ==== common/atmtx_regs.svh ====
// Register indices, field positions, reset values and cell constants
`ifndef ATMTX_REGS_SVH
`define ATMTX_REGS_SVH
`define ATMTX_IDX_CTRL 10'h0a0
`define ATMTX_IDX_ECC 10'h0a4
`define ATMTX_IDX_MASK 10'h0a6
`define ATMTX_IDX_HDR_LO 10'h0a8
`define ATMTX_IDX_HDR_HI 10'h0aa
`define ATMTX_IDX_PAY 10'h0ac
`define ATMTX_IDX_STAT 10'h0ae
`define ATMTX_IDX_LAT 10'h0b0
`define ATMTX_IDX_IE 10'h0b2
`define ATMTX_IDX_CNT_LO 10'h0b4
`define ATMTX_IDX_CNT_HI 10'h0b6
`define ATMTX_BIT_HDR_SEL 5
`define ATMTX_BIT_PAY_SEL 4
`define ATMTX_BIT_DONE 0
`define ATMTX_POS_RATE 8
`define ATMTX_POS_TOTAL 0
`define ATMTX_RST_HDR 32'h0000_0000
`define ATMTX_RST_PAY 8'h00
`define ATMTX_RST_MASK 8'h00
`define ATMTX_RST_ECC 15'h0000
`define ATMTX_RST_CNT 24'h00_0000
`define ATMTX_IDLE_HDR 32'h0000_0001
`define ATMTX_IDLE_PAY 8'h6a
`define ATMTX_TOTAL_CONT 8'hff
`define ATMTX_HEC_POLY 8'h07
`define ATMTX_HEC_COSET 8'h55
`define ATMTX_CELL_LAST 6'h34
`define ATMTX_HEC_IDX 6'h04
`define ATMTX_RESP_OKAY 2'h0
`define ATMTX_RESP_SLVERR 2'h2
`endif

// ==== common/atmtx_pkg.sv ====
// Types of the transmit fill and error insertion slice
package atmtx_pkg;
    typedef enum logic [1:0] {CST_DECIDE, CST_FETCH, CST_READY} atmtx_cell_st_t;
    typedef enum logic [3:0] {
        RID_NONE, RID_CTRL, RID_ECC, RID_MASK, RID_HLO, RID_HHI, RID_PAY,
        RID_STAT, RID_LAT, RID_IE, RID_CLO, RID_CHI
    } atmtx_rid_t;
    typedef struct packed {
        atmtx_cell_st_t cst;
        logic [5:0] idx;
        logic from_fifo;
        logic errored;
        logic [7:0] hold;
        logic hdr_sel;
        logic pay_sel;
        logic [6:0] rate;
        logic [7:0] total;
        logic [7:0] mask;
        logic [31:0] hdr;
        logic [7:0] pay;
        logic [23:0] ecnt;
        logic [7:0] sent;
        logic done;
        logic latched;
        logic ie;
        logic [23:0] run_cnt;
        logic [23:0] snap_cnt;
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [11:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic fifo_rd;
        logic tx_valid;
        logic tx_soc;
        logic [7:0] tx_data;
        logic irq;
    } atmtx_state_t;
endpackage : atmtx_pkg

// ==== tb/atmtx_core_properties.sv ====
// Port-level checks for the fill and error insertion slice
`timescale 1ns/1ps
module atmtx_core_properties (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Stream and interrupt
    input wire logic line_slot,
    input wire logic tx_valid,
    input wire logic tx_soc,
    input wire logic port_summary_irq_en,
    input wire logic irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_irq_port_gate: assert property (!$past(port_summary_irq_en) |-> !irq)
        else $error("irq without port enable");
    a_byte_after_slot: assert property (tx_valid |-> $past(line_slot))
        else $error("byte without line slot");
    a_soc_with_byte: assert property (tx_soc |-> tx_valid)
        else $error("cell start without byte");
    a_byte_spacing: assert property (tx_valid |=> !tx_valid [*2])
        else $error("bytes too close");
    a_cell_spacing: assert property (tx_soc |=> !tx_soc [*8])
        else $error("cell starts too close");
    a_wresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_wresp_cause: assert property ($rose(s_axi_bvalid) |->
        $past(s_axi_wvalid && s_axi_wready || s_axi_awvalid && s_axi_awready))
        else $error("write response without request");
    a_rresp_cause: assert property ($rose(s_axi_rvalid) |->
        $past(s_axi_arvalid && s_axi_arready))
        else $error("read data without request");
endmodule : atmtx_core_properties

bind atmtx_core atmtx_core_properties u_atmtx_core_properties (.*);

// ==== tb/atmtx_line_model.sv ====
// Remote line side: paces byte slots and captures whole cells
`timescale 1ns/1ps
module atmtx_line_model (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Slot pacing, three cycles or more
    input wire logic [7:0] slot_gap,
    output logic line_slot,
    // Cell stream
    input wire logic tx_valid,
    input wire logic tx_soc,
    input wire logic [7:0] tx_data
);
    logic [7:0] cur [53];
    logic [7:0] last_cell [53];
    int n_cells = 0;
    int pos = 0;
    int gap_cnt = 0;
    always @(posedge aclk) begin
        if (!aresetn) begin
            line_slot <= 1'b0;
            n_cells <= 0;
            pos <= 0;
            gap_cnt <= 0;
        end else begin
            line_slot <= (gap_cnt + 1 >= int'(slot_gap));
            gap_cnt <= (gap_cnt + 1 >= int'(slot_gap)) ? 0 : gap_cnt + 1;
            if (tx_valid) begin
                pos <= tx_soc ? 1 : pos + 1;
                cur[tx_soc ? 0 : pos] <= tx_data;
                if (!tx_soc && pos == 52) begin
                    foreach (cur[i]) last_cell[i] <= (i == 52) ? tx_data : cur[i];
                    n_cells <= n_cells + 1;
                end
            end
        end
    end
endmodule : atmtx_line_model

// ==== tb/atmtx_core_tb.sv ====
// Self-checking bench for the fill and error insertion slice
`timescale 1ns/1ps
`include "atmtx_regs.svh"
module atmtx_core_tb;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic fifo_cell_avail, fifo_rd, line_slot, tx_valid, tx_soc;
    logic perf_update_strobe, port_summary_irq_en, irq;
    logic [7:0] fifo_data, tx_data, slot_gap;
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;
    int n_pops = 0;

    atmtx_core u_atmtx_core (.*);
    atmtx_line_model u_atmtx_line_model (.*);

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    task automatic summarize();
        if (n_fail == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (fifo_rd === 1'b1) n_pops <= n_pops + 1;
        if (cyc == 40000) begin
            n_fail++;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic bus_wr(input logic [9:0] i, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= {i, 2'b00};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er}, "bresp");
    endtask : bus_wr

    task automatic bus_rd(input logic [9:0] i, input logic [31:0] ex, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= {i, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk({30'h0, s_axi_rresp}, {30'h0, er}, "rresp");
        chk(s_axi_rdata, ex, "rdata");
    endtask : bus_rd

    task automatic wr(input logic [9:0] i, input logic [31:0] d);
        bus_wr(i, d, `ATMTX_RESP_OKAY);
    endtask : wr

    task automatic rd(input logic [9:0] i, input logic [31:0] ex);
        bus_rd(i, ex, `ATMTX_RESP_OKAY);
    endtask : rd

    function automatic logic [7:0] lc(input int i);
        return u_atmtx_line_model.last_cell[i];
    endfunction : lc

    function automatic logic [7:0] hec_of(input logic [31:0] h);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 31; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? `ATMTX_HEC_POLY : 8'h00);
        return c ^ `ATMTX_HEC_COSET;
    endfunction : hec_of

    task automatic wait_cells(input int k);
        int t;
        t = u_atmtx_line_model.n_cells + k;
        while (u_atmtx_line_model.n_cells < t) @(posedge aclk);
    endtask : wait_cells

    task automatic chk_fill(input logic [31:0] h, input logic [7:0] p);
        int bad;
        bad = 0;
        wait_cells(2);
        chk({lc(0), lc(1), lc(2), lc(3)}, h, "fill header");
        chk({24'h0, lc(4)}, {24'h0, hec_of(h)}, "fill hec");
        for (int i = 5; i < 53; i++) bad += int'(lc(i) !== p);
        chk(bad, 0, "fill payload bytes");
    endtask : chk_fill

    task automatic t_regs();
        logic [9:0] regs [7] = '{`ATMTX_IDX_HDR_LO, `ATMTX_IDX_HDR_HI, `ATMTX_IDX_PAY,
            `ATMTX_IDX_MASK, `ATMTX_IDX_IE, `ATMTX_IDX_CNT_LO, `ATMTX_IDX_CNT_HI};
        foreach (regs[i]) rd(regs[i], 32'h0);
        wr(`ATMTX_IDX_PAY, 32'hffff_01a5);
        rd(`ATMTX_IDX_PAY, 32'h0000_00a5);
        wr(`ATMTX_IDX_CNT_LO, 32'h0000_1234);
        rd(`ATMTX_IDX_CNT_LO, 32'h0);
        bus_wr(10'h3ff, 32'h1, `ATMTX_RESP_SLVERR);
        bus_rd(10'h3ff, 32'h0, `ATMTX_RESP_SLVERR);
    endtask : t_regs

    task automatic t_fill();
        chk_fill(`ATMTX_IDLE_HDR, `ATMTX_IDLE_PAY);
        wr(`ATMTX_IDX_HDR_LO, 32'h5678);
        wr(`ATMTX_IDX_HDR_HI, 32'h1234);
        wr(`ATMTX_IDX_PAY, 32'h3c);
        wr(`ATMTX_IDX_CTRL, 32'h30);
        rd(`ATMTX_IDX_HDR_HI, 32'h1234);
        chk_fill(32'h1234_5678, 8'h3c);
        wr(`ATMTX_IDX_CTRL, 32'h20);
        chk_fill(32'h1234_5678, `ATMTX_IDLE_PAY);
        wr(`ATMTX_IDX_CTRL, 32'h10);
        chk_fill(`ATMTX_IDLE_HDR, 8'h3c);
    endtask : t_fill

    task automatic err_run(input logic [7:0] m, input logic [6:0] r, input logic [7:0] tot,
        input int n, input int lo, input int hi, input logic dn);
        int errs;
        logic [7:0] clean;
        errs = 0;
        wr(`ATMTX_IDX_MASK, {24'h0, m});
        wr(`ATMTX_IDX_ECC, {17'h0, r, tot});
        // Cell in flight may still carry the previous mask
        wait_cells(1);
        repeat (n) begin
            wait_cells(1);
            clean = hec_of({lc(0), lc(1), lc(2), lc(3)});
            if (m != 8'h00 && lc(4) === (clean ^ m)) errs++;
            else chk({24'h0, lc(4)}, {24'h0, clean}, "hec of clean cell");
        end
        total_checks++;
        if (errs < lo || errs > hi) begin
            n_fail++;
            $display("mismatch at %0t: %0d errored cells", $time, errs);
        end
        rd(`ATMTX_IDX_STAT, {31'h0, dn});
    endtask : err_run

    task automatic t_irq();
        rd(`ATMTX_IDX_LAT, 32'h1);
        port_summary_irq_en <= 1'b1;
        wr(`ATMTX_IDX_IE, 32'h1);
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, 32'h1, "irq raised");
        port_summary_irq_en <= 1'b0;
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, 32'h0, "irq with port off");
        port_summary_irq_en <= 1'b1;
        wr(`ATMTX_IDX_LAT, 32'h1);
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, 32'h0, "irq after clear");
        rd(`ATMTX_IDX_LAT, 32'h0);
        wr(`ATMTX_IDX_ECC, 32'h0);
        rd(`ATMTX_IDX_STAT, 32'h0);
    endtask : t_irq

    task automatic strobe();
        @(posedge aclk);
        perf_update_strobe <= 1'b1;
        @(posedge aclk);
        perf_update_strobe <= 1'b0;
    endtask : strobe

    task automatic t_count();
        int nf;
        int p0;
        nf = 0;
        slot_gap <= 8'd6;
        strobe();
        rd(`ATMTX_IDX_CNT_LO, 32'h0);
        p0 = n_pops;
        fifo_cell_avail <= 1'b1;
        while (nf < 3) begin
            wait_cells(1);
            nf += int'(lc(0) === 8'hc5);
        end
        fifo_cell_avail <= 1'b0;
        repeat (3) begin
            wait_cells(1);
            nf += int'(lc(0) === 8'hc5);
        end
        chk(n_pops - p0, 53 * nf, "fifo pops");
        rd(`ATMTX_IDX_CNT_LO, 32'h0);
        strobe();
        rd(`ATMTX_IDX_CNT_LO, nf);
        rd(`ATMTX_IDX_CNT_HI, 32'h0);
        strobe();
        rd(`ATMTX_IDX_CNT_LO, 32'h0);
    endtask : t_count

    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = 30'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        {fifo_cell_avail, perf_update_strobe, port_summary_irq_en} = 3'h0;
        fifo_data = 8'hc5;
        slot_gap = 8'd3;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_fill();
        err_run(8'h07, 7'h01, 8'h02, 5, 2, 2, 1'b1);
        t_irq();
        err_run(8'h00, 7'h01, 8'h01, 5, 0, 0, 1'b1);
        err_run(8'h0b, 7'h01, 8'hff, 5, 4, 5, 1'b0);
        err_run(8'h07, 7'h02, 8'h02, 7, 2, 2, 1'b1);
        err_run(8'h07, 7'h00, 8'h05, 5, 0, 0, 1'b0);
        t_count();
        summarize();
    end
endmodule : atmtx_core_tb
